// ---- rtl/rso_pkg.sv ----
// Constants shared by the remote status output block.
// Assumes a 32-bit plain register port with byte addresses.
package rso_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PROG_W = 6;
  localparam int FAULT_W = 14;
  localparam int AREA_W = 15;
  localparam int SEL_W = 5;
  localparam int MAX_ROBOTS = 16;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PROG = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FAULT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SELECT = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_AREA = 8'h10;

  // ************************************************************
  // Status word bit positions
  // ************************************************************
  localparam int BIT_READY = 0;
  localparam int BIT_RUN = 1;
  localparam int BIT_PAUSE = 2;
  localparam int BIT_ERROR = 3;
  localparam int BIT_GUARD = 5;
  localparam int BIT_CRIT = 6;
  localparam int BIT_WARN = 7;
  localparam int BIT_ESTOP_OFF = 8;
  localparam int BIT_ESTOP_ON = 9;
  localparam int BIT_MOTORS = 10;
  localparam int BIT_HOME = 11;
  localparam int BIT_POWER = 12;
  localparam int BIT_CAL = 13;
  localparam int BIT_REC_REQ = 14;
  localparam int BIT_REC_RUN = 15;
  localparam int BIT_HOST = 16;
  localparam int BIT_CMD_RUN = 17;
  localparam int BIT_CMD_REJ = 18;
  localparam int BIT_AUTO = 19;
  localparam int BIT_TEACH = 20;
  localparam int BIT_TEST = 21;
  localparam int BIT_ENABLE = 22;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [SEL_W-1:0] SEL_ALL = 5'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

endpackage : rso_pkg

// ---- rtl/rso_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
module rso_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ************************************************************
  // One pair of flops per bit
  // ************************************************************
  // First stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        meta_r[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta_r[i] <= d[i];
        q[i] <= meta_r[i];
      end
    end
  end

endmodule : rso_sync

// ---- rtl/rso_status.sv ----
// Remote status output generator: controller state to master lines.
// Assumes controller state inputs are on clk; master pins are not.
`timescale 1ns/1ps
module rso_status #(
  parameter int NUM_ROBOTS = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [rso_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rso_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rso_pkg::DATA_W-1:0] reg_rdata,
  // Controller state
  input wire logic startup_done,
  input wire logic task_running,
  input wire logic task_paused,
  input wire logic error_event,
  input wire logic critical_event,
  input wire logic [rso_pkg::FAULT_W-1:0] fault_code,
  input wire logic warning_active,
  input wire logic estop_active,
  input wire logic guard_open,
  input wire logic host_waiting,
  input wire logic command_busy,
  input wire logic command_start_event,
  input wire logic command_reject_event,
  input wire logic main_start_event,
  input wire logic [rso_pkg::PROG_W-1:0] main_number,
  input wire logic remote_accept,
  input wire logic teach_active,
  input wire logic test_active,
  input wire logic enable_switch,
  input wire logic [rso_pkg::AREA_W-1:0] area_inside,
  // Per-robot state
  input wire logic [NUM_ROBOTS-1:0] robot_motors_on,
  input wire logic [NUM_ROBOTS-1:0] robot_at_home,
  input wire logic [NUM_ROBOTS-1:0] robot_high_power,
  input wire logic [NUM_ROBOTS-1:0] robot_cal_needed,
  input wire logic [NUM_ROBOTS-1:0] robot_recover_wait,
  input wire logic [NUM_ROBOTS-1:0] robot_recovering,
  // Master pins
  input wire logic remote_reset_pin,
  input wire logic robot_select_pin,
  input wire logic [rso_pkg::SEL_W-1:0] robot_selection_bits,
  // Status outputs
  output logic ready_flag,
  output logic running_flag,
  output logic paused_flag,
  output logic error_flag,
  output logic emergency_stop_active,
  output logic guard_open_flag,
  output logic critical_fault_flag,
  output logic warning_flag,
  output logic emergency_stop_inactive,
  output logic motors_energised_flag,
  output logic home_position_flag,
  output logic high_power_flag,
  output logic calibration_required_flag,
  output logic recovery_required_flag,
  output logic recovery_in_progress_flag,
  output logic waiting_for_host_flag,
  output logic command_executing_flag,
  output logic command_rejected_flag,
  output logic [rso_pkg::PROG_W-1:0] program_number_bits,
  output logic automatic_mode_flag,
  output logic teach_mode_flag,
  output logic test_mode_flag,
  output logic enable_switch_flag,
  output logic [rso_pkg::FAULT_W-1:0] fault_number_bits,
  output logic [rso_pkg::AREA_W-1:0] approach_area_flags
);
  import rso_pkg::*;

  if (NUM_ROBOTS < 1 || NUM_ROBOTS > MAX_ROBOTS) begin : g_bad_robots
    $error("NUM_ROBOTS must lie between 1 and 16");
  end

  // ************************************************************
  // Master pin synchronisers
  // ************************************************************
  logic reset_sync;
  logic select_sync;
  logic [SEL_W-1:0] sel_bits_sync;
  logic reset_prev_r;
  logic select_prev_r;
  logic clear_pulse;
  logic select_pulse;
  logic [SEL_W-1:0] robot_sel_r;

  rso_sync #(.W(SEL_W + 2)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({remote_reset_pin, robot_select_pin, robot_selection_bits}),
    .q({reset_sync, select_sync, sel_bits_sync})
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reset_prev_r <= 1'b0;
      select_prev_r <= 1'b0;
    end else begin
      reset_prev_r <= reset_sync;
      select_prev_r <= select_sync;
    end
  end

  // Rising edges only, so a held pin acts once
  assign clear_pulse = reset_sync & ~reset_prev_r;
  assign select_pulse = select_sync & ~select_prev_r;

  // ************************************************************
  // Robot selection
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      robot_sel_r <= SEL_ALL;
    end else if (select_pulse) begin
      robot_sel_r <= sel_bits_sync;
    end else if (reg_wr && reg_addr == REG_SELECT) begin
      robot_sel_r <= reg_wdata[SEL_W-1:0];
    end
  end

  // All-robots view: any robot for on-style flags, every robot for home
  function automatic logic pick(input logic [NUM_ROBOTS-1:0] vec,
                                input logic [SEL_W-1:0] sel,
                                input logic need_all);
    logic res;
    res = 1'b0;
    if (sel == SEL_ALL) begin
      res = need_all ? &vec : |vec;
    end else if (int'(sel) <= NUM_ROBOTS) begin
      res = vec[int'(sel) - 1];
    end
    return res;
  endfunction : pick

  // ************************************************************
  // Task and safety flags
  // ************************************************************
  // Plain level tracking, refreshed every cycle without software help
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready_flag <= 1'b0;
      running_flag <= 1'b0;
      paused_flag <= 1'b0;
      emergency_stop_active <= 1'b0;
      emergency_stop_inactive <= 1'b0;
      guard_open_flag <= 1'b0;
      warning_flag <= 1'b0;
    end else begin
      ready_flag <= startup_done & ~task_running;
      running_flag <= task_running & ~task_paused;
      paused_flag <= task_paused;
      emergency_stop_active <= estop_active;
      emergency_stop_inactive <= ~estop_active;
      guard_open_flag <= guard_open;
      warning_flag <= warning_active;
    end
  end

  // ************************************************************
  // Latched faults
  // ************************************************************
  // A new fault in the clearing cycle wins over the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      error_flag <= 1'b0;
    end else if (error_event) begin
      error_flag <= 1'b1;
    end else if (clear_pulse) begin
      error_flag <= 1'b0;
    end
  end

  // Only a controller restart (rst_n) clears this one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      critical_fault_flag <= 1'b0;
    end else if (critical_event) begin
      critical_fault_flag <= 1'b1;
    end
  end

  // Number stays while a critical fault blocks recovery
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_number_bits <= '0;
    end else if (error_event || critical_event) begin
      fault_number_bits <= fault_code;
    end else if (clear_pulse && !critical_fault_flag) begin
      fault_number_bits <= '0;
    end
  end

  // ************************************************************
  // Robot flags
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      motors_energised_flag <= 1'b0;
      home_position_flag <= 1'b0;
      high_power_flag <= 1'b0;
      calibration_required_flag <= 1'b0;
      recovery_required_flag <= 1'b0;
      recovery_in_progress_flag <= 1'b0;
    end else begin
      motors_energised_flag <= pick(robot_motors_on, robot_sel_r, 1'b0);
      home_position_flag <= pick(robot_at_home, robot_sel_r, 1'b1);
      high_power_flag <= pick(robot_high_power, robot_sel_r, 1'b0);
      calibration_required_flag <= pick(robot_cal_needed, robot_sel_r, 1'b0);
      recovery_required_flag <= |robot_recover_wait;
      recovery_in_progress_flag <= |robot_recovering;
    end
  end

  // ************************************************************
  // Command handshake and modes
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waiting_for_host_flag <= 1'b0;
      command_executing_flag <= 1'b0;
      automatic_mode_flag <= 1'b0;
      teach_mode_flag <= 1'b0;
      test_mode_flag <= 1'b0;
      enable_switch_flag <= 1'b0;
      approach_area_flags <= '0;
    end else begin
      waiting_for_host_flag <= host_waiting;
      command_executing_flag <= command_busy;
      automatic_mode_flag <= remote_accept;
      teach_mode_flag <= teach_active;
      // Teach wins so the two never show together
      test_mode_flag <= test_active & ~teach_active;
      enable_switch_flag <= enable_switch;
      approach_area_flags <= area_inside;
    end
  end

  // Rejection stays until the next command is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      command_rejected_flag <= 1'b0;
    end else if (command_reject_event) begin
      command_rejected_flag <= 1'b1;
    end else if (command_start_event) begin
      command_rejected_flag <= 1'b0;
    end
  end

  // Holds the last number after the function ends
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      program_number_bits <= '0;
    end else if (main_start_event) begin
      program_number_bits <= main_number;
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  logic [DATA_W-1:0] status_word;

  always_comb begin
    status_word = READ_ZERO;
    status_word[BIT_READY] = ready_flag;
    status_word[BIT_RUN] = running_flag;
    status_word[BIT_PAUSE] = paused_flag;
    status_word[BIT_ERROR] = error_flag;
    status_word[BIT_GUARD] = guard_open_flag;
    status_word[BIT_CRIT] = critical_fault_flag;
    status_word[BIT_WARN] = warning_flag;
    status_word[BIT_ESTOP_OFF] = emergency_stop_inactive;
    status_word[BIT_ESTOP_ON] = emergency_stop_active;
    status_word[BIT_MOTORS] = motors_energised_flag;
    status_word[BIT_HOME] = home_position_flag;
    status_word[BIT_POWER] = high_power_flag;
    status_word[BIT_CAL] = calibration_required_flag;
    status_word[BIT_REC_REQ] = recovery_required_flag;
    status_word[BIT_REC_RUN] = recovery_in_progress_flag;
    status_word[BIT_HOST] = waiting_for_host_flag;
    status_word[BIT_CMD_RUN] = command_executing_flag;
    status_word[BIT_CMD_REJ] = command_rejected_flag;
    status_word[BIT_AUTO] = automatic_mode_flag;
    status_word[BIT_TEACH] = teach_mode_flag;
    status_word[BIT_TEST] = test_mode_flag;
    status_word[BIT_ENABLE] = enable_switch_flag;
  end

  // Data only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= READ_ZERO;
    end else if (!reg_rd) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_addr == REG_STATUS) begin
      reg_rdata <= status_word;
    end else if (reg_addr == REG_PROG) begin
      reg_rdata <= {{(DATA_W - PROG_W){1'b0}}, program_number_bits};
    end else if (reg_addr == REG_FAULT) begin
      reg_rdata <= {{(DATA_W - FAULT_W){1'b0}}, fault_number_bits};
    end else if (reg_addr == REG_SELECT) begin
      reg_rdata <= {{(DATA_W - SEL_W){1'b0}}, robot_sel_r};
    end else if (reg_addr == REG_AREA) begin
      reg_rdata <= {{(DATA_W - AREA_W){1'b0}}, approach_area_flags};
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ready;
    startup_done && !task_running |=> ready_flag;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not shown");

  property p_run_pause;
    task_paused |=> !running_flag && paused_flag;
  endproperty
  a_run_pause: assert property (p_run_pause) else $error("run shown in pause");

  sequence s_fault_hit;
    error_event ##1 (!clear_pulse)[*2];
  endsequence

  property p_error_hold;
    s_fault_hit |-> error_flag;
  endproperty
  a_error_hold: assert property (p_error_hold) else $error("error lost");

  sequence s_pin_reset;
    $rose(remote_reset_pin) ##1 remote_reset_pin[*2];
  endsequence

  property p_error_clear;
    (!error_event) throughout s_pin_reset |=> !error_flag;
  endproperty
  a_error_clear: assert property (p_error_clear) else $error("error not cleared");

  property p_estop;
    estop_active |=> emergency_stop_active && !emergency_stop_inactive;
  endproperty
  a_estop: assert property (p_estop) else $error("estop lines wrong");

  property p_crit_sticky;
    critical_fault_flag |=> critical_fault_flag;
  endproperty
  a_crit_sticky: assert property (p_crit_sticky) else $error("critical cleared");

  property p_reject;
    command_reject_event |=> command_rejected_flag;
  endproperty
  a_reject: assert property (p_reject) else $error("reject missed");

  property p_prog;
    main_start_event |=> program_number_bits == $past(main_number);
  endproperty
  a_prog: assert property (p_prog) else $error("program number wrong");

  property p_modes;
    !(teach_mode_flag && test_mode_flag);
  endproperty
  a_modes: assert property (p_modes) else $error("teach and test both on");

  property p_all_motors;
    robot_sel_r == SEL_ALL |=> motors_energised_flag == ($past(robot_motors_on) != '0);
  endproperty
  a_all_motors: assert property (p_all_motors) else $error("all-robot motors wrong");

endmodule : rso_status

// ---- verif/rso_master.sv ----
// Master equipment model: drives the remote reset and robot select pins.
// Assumes the bench calls its tasks; pins change only after a rising edge.
`timescale 1ns/1ps
module rso_master (
  // Clock
  input wire logic clk,
  // Master pins
  output logic remote_reset_pin,
  output logic robot_select_pin,
  output logic [rso_pkg::SEL_W-1:0] robot_selection_bits
);
  import rso_pkg::*;
  initial begin
    remote_reset_pin = 1'b0;
    robot_select_pin = 1'b0;
    robot_selection_bits = 5'h1F;
  end
  // Pulses held 3 cycles and gapped 3, to pass the pin synchroniser
  task pulse_reset();
    @(posedge clk);
    remote_reset_pin <= 1'b1;
    repeat (3) @(posedge clk);
    remote_reset_pin <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse_reset
  task select(input logic [SEL_W-1:0] v);
    @(posedge clk);
    robot_selection_bits <= v;
    @(posedge clk);
    robot_select_pin <= 1'b1;
    repeat (3) @(posedge clk);
    robot_select_pin <= 1'b0;
    // Released lines show the inverse, never the stale value
    robot_selection_bits <= ~v;
    repeat (3) @(posedge clk);
  endtask : select
endmodule : rso_master

// ---- verif/rso_status_bench.sv ----
// Self-checking bench for the remote status output generator.
// Assumes rso_status and rso_master; one 100 MHz clock.
`timescale 1ns/1ps
module rso_status_bench;
  import rso_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic su = 0, tr = 0, tp = 0, ee = 0, ce = 0, wa = 0, ea = 0, go = 0, hw = 0;
  logic cb = 0, cs = 0, cr = 0, ms = 0, ra = 0, ta = 0, te = 0, en = 0;
  logic [FAULT_W-1:0] fc = 14'h0;
  logic [PROG_W-1:0] mn = 6'h0;
  logic [AREA_W-1:0] ar = 15'h0;
  logic [15:0] mo = 16'h0, ho = 16'h0, hp = 16'h0, ca = 16'h0, rw = 16'h0, rr = 16'h0;
  logic rst_pin, sel_pin;
  logic [SEL_W-1:0] sel_bits;
  wire [31:0] o;
  logic [PROG_W-1:0] prog;
  logic [FAULT_W-1:0] fault;
  logic [AREA_W-1:0] area;
  int error_cnt = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  rso_master rso_master_inst (.clk(clk), .remote_reset_pin(rst_pin),
    .robot_select_pin(sel_pin), .robot_selection_bits(sel_bits));
  rso_status rso_status_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .startup_done(su), .task_running(tr), .task_paused(tp), .error_event(ee),
    .critical_event(ce), .fault_code(fc), .warning_active(wa), .estop_active(ea),
    .guard_open(go), .host_waiting(hw), .command_busy(cb), .command_start_event(cs),
    .command_reject_event(cr), .main_start_event(ms), .main_number(mn),
    .remote_accept(ra), .teach_active(ta), .test_active(te), .enable_switch(en),
    .area_inside(ar), .robot_motors_on(mo), .robot_at_home(ho), .robot_high_power(hp),
    .robot_cal_needed(ca), .robot_recover_wait(rw), .robot_recovering(rr),
    .remote_reset_pin(rst_pin), .robot_select_pin(sel_pin),
    .robot_selection_bits(sel_bits),
    .ready_flag(o[BIT_READY]), .running_flag(o[BIT_RUN]), .paused_flag(o[BIT_PAUSE]),
    .error_flag(o[BIT_ERROR]), .emergency_stop_active(o[BIT_ESTOP_ON]),
    .guard_open_flag(o[BIT_GUARD]), .critical_fault_flag(o[BIT_CRIT]),
    .warning_flag(o[BIT_WARN]), .emergency_stop_inactive(o[BIT_ESTOP_OFF]),
    .motors_energised_flag(o[BIT_MOTORS]), .home_position_flag(o[BIT_HOME]),
    .high_power_flag(o[BIT_POWER]), .calibration_required_flag(o[BIT_CAL]),
    .recovery_required_flag(o[BIT_REC_REQ]), .recovery_in_progress_flag(o[BIT_REC_RUN]),
    .waiting_for_host_flag(o[BIT_HOST]), .command_executing_flag(o[BIT_CMD_RUN]),
    .command_rejected_flag(o[BIT_CMD_REJ]), .program_number_bits(prog),
    .automatic_mode_flag(o[BIT_AUTO]), .teach_mode_flag(o[BIT_TEACH]),
    .test_mode_flag(o[BIT_TEST]), .enable_switch_flag(o[BIT_ENABLE]),
    .fault_number_bits(fault), .approach_area_flags(area));
  assign o[4] = 1'b0;
  assign o[31:23] = 9'h0;
  // ************************************************************
  // Tasks
  // ************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task step();
    @(posedge clk);
    #1;
  endtask : step
  task rd_reg(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd_reg
  task wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr_reg
  task finish_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(o, 32'h0);
    repeat (3) step();
    chk(o, 32'h1 << BIT_ESTOP_OFF);
    @(posedge clk);
    su <= 1'b1;
    step();
    chk(o[2:0], 3'h1);
    @(posedge clk);
    tr <= 1'b1;
    step();
    chk(o[2:0], 3'h2);
    @(posedge clk);
    tp <= 1'b1;
    step();
    chk(o[2:0], 3'h4);
    // Error latches until the master's reset pin
    @(posedge clk);
    ee <= 1'b1;
    fc <= 14'h2000;
    @(posedge clk);
    ee <= 1'b0;
    repeat (3) step();
    chk({o[BIT_ERROR], 2'h0, fault}, {1'b1, 2'h0, 14'h2000});
    rso_master_inst.pulse_reset();
    #1 chk({o[BIT_ERROR], 2'h0, fault}, 17'h0);
    // Critical fault survives the remote reset
    @(posedge clk);
    ce <= 1'b1;
    fc <= 14'h0015;
    @(posedge clk);
    ce <= 1'b0;
    rso_master_inst.pulse_reset();
    #1 chk({o[BIT_CRIT], 2'h0, fault}, {1'b1, 2'h0, 14'h0015});
    // Level flags all at once
    @(posedge clk);
    {wa, ea, go, hw, cb, ra, ta, en} <= 8'hFF;
    ar <= 15'h7FFF;
    rw <= 16'h8000;
    rr <= 16'h0002;
    te <= 1'b1;
    step();
    step();
    chk(o, 32'h5BC2E4);
    chk(area, 15'h7FFF);
    rd_reg(REG_STATUS, 32'h5BC2E4);
    rd_reg(REG_AREA, 32'h7FFF);
    @(posedge clk);
    ta <= 1'b0;
    step();
    step();
    chk(o[21:20], 2'h2);
    // Program number, both ends of the range
    @(posedge clk);
    ms <= 1'b1;
    mn <= 6'h3F;
    @(posedge clk);
    ms <= 1'b0;
    mn <= 6'h00;
    step();
    chk(prog, 6'h3F);
    rd_reg(REG_PROG, 32'h3F);
    @(posedge clk);
    ms <= 1'b1;
    @(posedge clk);
    ms <= 1'b0;
    step();
    chk(prog, 6'h00);
    // Rejected command until the next accepted one
    @(posedge clk);
    cr <= 1'b1;
    @(posedge clk);
    cr <= 1'b0;
    step();
    chk(o[BIT_CMD_REJ], 1'b1);
    @(posedge clk);
    cs <= 1'b1;
    @(posedge clk);
    cs <= 1'b0;
    step();
    chk(o[BIT_CMD_REJ], 1'b0);
    // Robot selection: all, then robot 3 by register, robot 1 by pin
    @(posedge clk);
    mo <= 16'h0004;
    ho <= 16'hFFFB;
    hp <= 16'h0001;
    ca <= 16'h0004;
    step();
    step();
    chk(o[13:10], 4'hD);
    wr_reg(REG_SELECT, 32'h3);
    chk(o[13:10], 4'h9);
    rso_master_inst.select(5'h01);
    #1 chk(o[13:10], 4'h6);
    rd_reg(REG_SELECT, 32'h1);
    // Read-only and unmapped places
    wr_reg(REG_STATUS, 32'hFFFFFFFF);
    rd_reg(REG_SELECT, 32'h1);
    rd_reg(8'h14, 32'h0);
    // Restart clears the critical fault and the selection
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(REG_SELECT, 32'h0);
    chk({o[BIT_CRIT], 2'h0, fault}, 17'h0);
    finish_test();
  end
  // Run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule : rso_status_bench
